//--- src/pso_strap_override.sv
// Purpose: picks strap or NVM source per setting, holds bus address
// Assumes: protocol engine gives decoded command pulses on this clock
// Notes:   checksum value is computed outside and given on i_nvm_csum
`timescale 1ns/1ps
`include "pso_defs.svh"
module pso_strap_override
   import pso_pkg::*;
#(
   parameter int NFIELDS = `PSO_NUM_FIELDS
) (
   input  wire logic      i_core_clk,
   input  wire logic      i_arst_n,
   input  wire pso_cfg_t  i_strap_pins,
   input  wire pso_cfg_t  i_nvm_cfg,
   input  wire pso_word_t i_nvm_ovr,
   input  wire pso_word_t i_nvm_csum,
   input  wire logic      i_reload,
   input  wire pso_req_t  i_req,
   input  wire logic [6:0] i_bus_addr,
   output pso_cfg_t       o_cfg,
   output pso_word_t      o_ovr,
   output pso_rsp_t       o_rsp,
   output logic           o_addr_match
);

   // elaboration check: the carrier struct is laid out for nine fields only
   if (NFIELDS != `PSO_NUM_FIELDS) begin : g_bad_nfields
      $error("field count fixed at nine");
   end

   ////////////////////////////////////////////////////////////////////////
   // helpers

   // reserved target addresses cannot be programmed
   function automatic logic is_rsvd(input logic [6:0] a);
      is_rsvd = (a == `PSO_RSVD_ADDR0) || (a == `PSO_RSVD_ADDR1) ||
                (a == `PSO_RSVD_ADDR2) || (a == `PSO_RSVD_ADDR3);
   endfunction

   // per-field source selection, override bit high keeps strap
   function automatic pso_cfg_t pick(input pso_word_t ovr, input pso_cfg_t s, input pso_cfg_t n);
      pso_cfg_t c;
      c       = n;
      c.stack = ovr[`PSO_BIT_STACK] ? s.stack : n.stack;
      c.sync  = ovr[`PSO_BIT_SYNC]  ? s.sync  : n.sync;
      c.comp  = ovr[`PSO_BIT_COMP]  ? s.comp  : n.comp;
      c.addr  = ovr[`PSO_BIT_ADDR]  ? s.addr  : n.addr;
      c.ilv   = ovr[`PSO_BIT_ILV]   ? s.ilv   : n.ilv;
      c.ton   = ovr[`PSO_BIT_TON]   ? s.ton   : n.ton;
      c.ioc   = ovr[`PSO_BIT_IOC]   ? s.ioc   : n.ioc;
      c.fsw   = ovr[`PSO_BIT_FSW]   ? s.fsw   : n.fsw;
      c.output_voltage_group_src  = ovr[`PSO_BIT_OUTPUT_VOLTAGE_GROUP_SRC]  ? s.output_voltage_group_src  : n.output_voltage_group_src;
      // bits 10 and 4 are never looked at here
      pick    = c;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // strap synchroniser: pins are outside the clock domain

   pso_cfg_t strap_s1_r;
   pso_cfg_t strap_s2_r;

   // first stage read only by the second
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         strap_s1_r <= '0;
         strap_s2_r <= '0;
      end else begin
         strap_s1_r <= i_strap_pins;
         strap_s2_r <= strap_s1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state

   pso_state_t st_r;
   pso_state_t st_nxt;
   logic       boot_r;  // two-cycle gap so the sync chain has settled
   logic [1:0] boot_cnt_r;

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         boot_cnt_r <= 2'h0;
      end else if (boot_cnt_r != 2'h3) begin
         boot_cnt_r <= boot_cnt_r + 2'h1;
      end
   end
   assign boot_r = (boot_cnt_r == 2'h2);

   logic addr_wr;
   logic rsvd_hit;
   assign addr_wr  = i_req.wr && (i_req.cmd == `PSO_CMD_ADDRESS) && !i_req.word;
   assign rsvd_hit = is_rsvd(i_req.data[6:0]);

   // next-state logic; host access and reloads
   always_comb begin
      st_nxt         = st_r;
      st_nxt.rsp     = '0;
      st_nxt.match   = (i_bus_addr == st_r.live.addr[6:0]);
      if (boot_r && !st_r.strap_taken) begin
         // straps captured once, after reset release
         st_nxt.strap_taken = 1'b1;
         st_nxt.strap       = strap_s2_r;
         st_nxt.ovr         = i_nvm_ovr;
         st_nxt.live        = pick(i_nvm_ovr, strap_s2_r, i_nvm_cfg);
         st_nxt.csum        = i_nvm_csum;
      end else if (i_reload && st_r.strap_taken) begin
         // restore reuses the captured straps, never resamples
         st_nxt.live = pick(st_r.ovr, st_r.strap, i_nvm_cfg);
         st_nxt.csum = i_nvm_csum;
      end else if (i_req.wr) begin
         case (i_req.cmd)
            `PSO_CMD_OVERRIDE: begin
               // word write, live at once but used only on reload
               if (i_req.word) begin
                  st_nxt.ovr     = i_req.data;
                  st_nxt.rsp.ack = 1'b1;
               end else begin
                  st_nxt.rsp.invalid = 1'b1;
               end
            end
            `PSO_CMD_ADDRESS: begin
               if (addr_wr && !rsvd_hit) begin
                  st_nxt.live.addr = {9'h000, i_req.data[6:0]};
                  st_nxt.rsp.ack   = 1'b1;
               end else begin
                  st_nxt.rsp.invalid = 1'b1; // old address kept
               end
            end
            `PSO_CMD_CHECKSUM: st_nxt.rsp.invalid = 1'b1;
            default: st_nxt.rsp.invalid = 1'b1;
         endcase
      end else if (i_req.rd) begin
         case (i_req.cmd)
            `PSO_CMD_OVERRIDE: begin
               st_nxt.rsp.invalid = !i_req.word;
               st_nxt.rsp.ack     = i_req.word;
               st_nxt.rsp.data    = st_r.ovr;
            end
            `PSO_CMD_ADDRESS: begin
               st_nxt.rsp.invalid = i_req.word;
               st_nxt.rsp.ack     = !i_req.word;
               st_nxt.rsp.data    = st_r.live.addr & {8'h00, `PSO_ADDR_MASK};
            end
            `PSO_CMD_CHECKSUM: begin
               st_nxt.rsp.invalid = !i_req.word;
               st_nxt.rsp.ack     = i_req.word;
               st_nxt.rsp.data    = st_r.csum;
            end
            default: st_nxt.rsp.invalid = 1'b1;
         endcase
      end
   end

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs from flip-flops
   assign o_cfg        = st_r.live;
   assign o_ovr        = st_r.ovr;
   assign o_rsp        = st_r.rsp;
   assign o_addr_match = st_r.match;

   ////////////////////////////////////////////////////////////////////////
   // checks

   property p_strap_kept;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      (i_reload && st_r.strap_taken && !boot_r && st_r.ovr[`PSO_BIT_ADDR])
         |=> (st_r.live.addr == $past(st_r.strap.addr));
   endproperty
   a_strap_kept: assert property (p_strap_kept) else $error("strap address not kept");

   property p_nvm_taken;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      (i_reload && st_r.strap_taken && !boot_r && !st_r.ovr[`PSO_BIT_OUTPUT_VOLTAGE_GROUP_SRC])
         |=> (st_r.live.output_voltage_group_src == $past(i_nvm_cfg.output_voltage_group_src));
   endproperty
   a_nvm_taken: assert property (p_nvm_taken) else $error("voltage group not from nvm");

   property p_strap_once;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      st_r.strap_taken |=> $stable(st_r.strap);
   endproperty
   a_strap_once: assert property (p_strap_once) else $error("straps resampled");

   property p_rsvd_refused;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      (addr_wr && rsvd_hit && !i_reload && !boot_r)
         |=> (st_r.rsp.invalid && $stable(st_r.live.addr));
   endproperty
   a_rsvd_refused: assert property (p_rsvd_refused) else $error("reserved address accepted");

   property p_addr_bit7;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      (st_r.rsp.ack && $past(i_req.rd) && $past(i_req.cmd) == `PSO_CMD_ADDRESS) |-> !st_r.rsp.data[7];
   endproperty
   a_addr_bit7: assert property (p_addr_bit7) else $error("address bit 7 set");

   property p_new_addr;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      (addr_wr && !rsvd_hit && !i_reload && st_r.strap_taken)
         ##1 (i_bus_addr == $past(i_req.data[6:0])) |=> o_addr_match;
   endproperty
   a_new_addr: assert property (p_new_addr) else $error("new address not answered");

   property p_csum_wr;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      (i_req.wr && i_req.cmd == `PSO_CMD_CHECKSUM && !i_reload && st_r.strap_taken)
         |=> (st_r.rsp.invalid && !st_r.rsp.ack);
   endproperty
   a_csum_wr: assert property (p_csum_wr) else $error("checksum write accepted");

   property p_csum_reload;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      (i_reload && st_r.strap_taken && !boot_r) |=> (st_r.csum == $past(i_nvm_csum));
   endproperty
   a_csum_reload: assert property (p_csum_reload) else $error("checksum not refreshed");

   property p_ovr_write;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      (i_req.wr && i_req.word && i_req.cmd == `PSO_CMD_OVERRIDE && !i_reload && st_r.strap_taken)
         |=> (st_r.ovr == $past(i_req.data)) && $stable(st_r.live);
   endproperty
   a_ovr_write: assert property (p_ovr_write) else $error("override write misbehaved");

   // restore source per field; override word cannot change in a reload cycle
   property p_stack_src;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      (i_reload && st_r.strap_taken && !boot_r)
         |=> st_r.live.stack == (st_r.ovr[`PSO_BIT_STACK] ? $past(st_r.strap.stack) : $past(i_nvm_cfg.stack));
   endproperty
   a_stack_src: assert property (p_stack_src) else $error("stack source wrong");

   property p_sync_src;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      (i_reload && st_r.strap_taken && !boot_r)
         |=> st_r.live.sync == (st_r.ovr[`PSO_BIT_SYNC] ? $past(st_r.strap.sync) : $past(i_nvm_cfg.sync));
   endproperty
   a_sync_src: assert property (p_sync_src) else $error("sync source wrong");

   property p_comp_src;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      (i_reload && st_r.strap_taken && !boot_r)
         |=> st_r.live.comp == (st_r.ovr[`PSO_BIT_COMP] ? $past(st_r.strap.comp) : $past(i_nvm_cfg.comp));
   endproperty
   a_comp_src: assert property (p_comp_src) else $error("compensation source wrong");

   property p_addr_src;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      (i_reload && st_r.strap_taken && !boot_r)
         |=> st_r.live.addr == (st_r.ovr[`PSO_BIT_ADDR] ? $past(st_r.strap.addr) : $past(i_nvm_cfg.addr));
   endproperty
   a_addr_src: assert property (p_addr_src) else $error("address source wrong");

   property p_ilv_src;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      (i_reload && st_r.strap_taken && !boot_r)
         |=> st_r.live.ilv == (st_r.ovr[`PSO_BIT_ILV] ? $past(st_r.strap.ilv) : $past(i_nvm_cfg.ilv));
   endproperty
   a_ilv_src: assert property (p_ilv_src) else $error("interleave source wrong");

   property p_ton_src;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      (i_reload && st_r.strap_taken && !boot_r)
         |=> st_r.live.ton == (st_r.ovr[`PSO_BIT_TON] ? $past(st_r.strap.ton) : $past(i_nvm_cfg.ton));
   endproperty
   a_ton_src: assert property (p_ton_src) else $error("soft-start source wrong");

   property p_ioc_src;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      (i_reload && st_r.strap_taken && !boot_r)
         |=> st_r.live.ioc == (st_r.ovr[`PSO_BIT_IOC] ? $past(st_r.strap.ioc) : $past(i_nvm_cfg.ioc));
   endproperty
   a_ioc_src: assert property (p_ioc_src) else $error("current limit source wrong");

   property p_fsw_src;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      (i_reload && st_r.strap_taken && !boot_r)
         |=> st_r.live.fsw == (st_r.ovr[`PSO_BIT_FSW] ? $past(st_r.strap.fsw) : $past(i_nvm_cfg.fsw));
   endproperty
   a_fsw_src: assert property (p_fsw_src) else $error("switching rate source wrong");

   // boot load: address from strap or nvm as the stored override says
   property p_boot_addr;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      (boot_r && !st_r.strap_taken)
         |=> st_r.live.addr == (st_r.ovr[`PSO_BIT_ADDR] ? $past(strap_s2_r.addr) : $past(i_nvm_cfg.addr));
   endproperty
   a_boot_addr: assert property (p_boot_addr) else $error("boot address source wrong");

   property p_boot_csum;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      (boot_r && !st_r.strap_taken)
         |=> (st_r.csum == $past(i_nvm_csum));
   endproperty
   a_boot_csum: assert property (p_boot_csum) else $error("checksum not taken at boot");

   // once captured, straps stay captured until the next power-on reset
   property p_strap_sticky;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      st_r.strap_taken
         |=> st_r.strap_taken;
   endproperty
   a_strap_sticky: assert property (p_strap_sticky) else $error("strap capture lost");

   property p_rsp_onehot;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      !(st_r.rsp.ack && st_r.rsp.invalid);
   endproperty
   a_rsp_onehot: assert property (p_rsp_onehot) else $error("ack and invalid together");

   c_boot:   cover property (@(posedge i_core_clk) disable iff (!i_arst_n) $rose(st_r.strap_taken));
   c_reload: cover property (@(posedge i_core_clk) disable iff (!i_arst_n) i_reload && st_r.strap_taken);
   c_rsvd:   cover property (@(posedge i_core_clk) disable iff (!i_arst_n) addr_wr && rsvd_hit);
   c_newadr: cover property (@(posedge i_core_clk) disable iff (!i_arst_n) addr_wr && !rsvd_hit);

endmodule

//--- src/pso_defs.svh
// Purpose: constants for the strap override and bus address block
// Assumes: byte-wide command codes, word registers of 16 bits
// Notes:   offsets are command codes
`ifndef PSO_DEFS_SVH
`define PSO_DEFS_SVH
`define PSO_CMD_OVERRIDE   8'hee
`define PSO_CMD_ADDRESS    8'hef
`define PSO_CMD_CHECKSUM   8'hf0
`define PSO_BIT_STACK      12
`define PSO_BIT_SYNC       11
`define PSO_BIT_COMP       9
`define PSO_BIT_ADDR       8
`define PSO_BIT_ILV        5
`define PSO_BIT_TON        3
`define PSO_BIT_IOC        2
`define PSO_BIT_FSW        1
`define PSO_BIT_OUTPUT_VOLTAGE_GROUP_SRC       0
`define PSO_OVR_USED_MASK  16'h1b2f
`define PSO_ADDR_MASK      8'h7f
`define PSO_RSVD_ADDR0     7'h0c
`define PSO_RSVD_ADDR1     7'h28
`define PSO_RSVD_ADDR2     7'h37
`define PSO_RSVD_ADDR3     7'h61
`define PSO_NUM_FIELDS     9
`endif

//--- src/pso_pkg.sv
// Purpose: types for the strap override and bus address block
// Assumes: pso_defs.svh holds all numbers
// Notes:   one settings word per reloadable field
package pso_pkg;
   typedef logic [15:0] pso_word_t;
   // one 16-bit image per field, index = override bit position group
   typedef struct packed {
      pso_word_t stack;
      pso_word_t sync;
      pso_word_t comp;
      pso_word_t addr;
      pso_word_t ilv;
      pso_word_t ton;
      pso_word_t ioc;
      pso_word_t fsw;
      pso_word_t output_voltage_group_src;
   } pso_cfg_t;
   // host command port
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] cmd;
      logic       word;
      pso_word_t  data;
   } pso_req_t;
   typedef struct packed {
      logic      ack;
      logic      invalid;
      pso_word_t data;
   } pso_rsp_t;
   typedef struct packed {
      logic      strap_taken;
      pso_word_t ovr;
      pso_cfg_t  strap;
      pso_cfg_t  live;
      pso_word_t csum;
      pso_rsp_t  rsp;
      logic      match;
   } pso_state_t;
endpackage

//--- tb/pso_host_model.sv
// Purpose: host side of the decoded command port
// Assumes: one request per cycle, answer one cycle after it is taken
// Notes:   drives at the falling edge, samples the answer at the next one
`timescale 1ns/1ps
module pso_host_model
   import pso_pkg::*;
(
   input  wire logic     i_core_clk,
   input  wire pso_rsp_t i_rsp,
   output pso_req_t      o_req
);
   initial o_req = '0;
   ////////////////////////////////////////////////////////////////////////////
   // one transfer; request held across exactly one rising edge
   task automatic xfer(input logic wr, input logic [7:0] cmd, input logic word,
                       input pso_word_t data, output pso_rsp_t rsp);
      @(negedge i_core_clk);
      o_req.wr   = wr;
      o_req.rd   = !wr;
      o_req.cmd  = cmd;
      o_req.word = word;
      // the host clears override bits 15 to 13, 7 and 6 but passes the unused bits 10 and 4
      o_req.data = (wr && cmd == 8'hee) ? (data & 16'h1f3f) : data;
      @(negedge i_core_clk);
      rsp   = i_rsp;
      o_req = '0;
   endtask
endmodule

//--- tb/pin_strap_override_and_address_bench.sv
// Purpose: directed checks of source selection, address and checksum
// Assumes: host model owns the command port timing
// Notes:   straps are changed after boot to prove they are sampled once
`timescale 1ns/1ps
module pin_strap_override_and_address_bench
   import pso_pkg::*;
;
   logic       clk = 1'b0;
   logic       arst_n = 1'b0;
   pso_cfg_t   strap, nvm, cfg, bs;
   pso_word_t  nvm_ovr, nvm_csum, ovr;
   logic       reload;
   pso_req_t   req;
   pso_rsp_t   rsp, r;
   logic [6:0] bus_addr;
   logic       match;
   int         n_mismatch = 0;
   int         checked = 0;
   logic [6:0] rsvd_list [4] = '{7'h0c, 7'h28, 7'h37, 7'h61};

   always #20 clk = ~clk;

   pso_strap_override DUT (.i_core_clk(clk), .i_arst_n(arst_n), .i_strap_pins(strap), .i_nvm_cfg(nvm),
      .i_nvm_ovr(nvm_ovr), .i_nvm_csum(nvm_csum), .i_reload(reload), .i_req(req), .i_bus_addr(bus_addr),
      .o_cfg(cfg), .o_ovr(ovr), .o_rsp(rsp), .o_addr_match(match));
   pso_host_model HOST (.i_core_clk(clk), .i_rsp(rsp), .o_req(req));

   ////////////////////////////////////////////////////////////////////////////
   // expected live settings: strap where the override bit is set
   function automatic pso_cfg_t pick(pso_word_t o, pso_cfg_t s, pso_cfg_t n);
      int bitpos [9] = '{12, 11, 9, 8, 5, 3, 2, 1, 0};
      pick = n;
      for (int k = 0; k < 9; k++) begin
         if (o[bitpos[k]]) pick[(8-k)*16 +: 16] = s[(8-k)*16 +: 16];
      end
   endfunction

   task automatic chk(input string nm, input logic [143:0] e, input logic [143:0] g);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic end_of_test;
      $display("checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic wr(input logic [7:0] c, input logic w, input pso_word_t d);
      HOST.xfer(1'b1, c, w, d, r);
   endtask

   task automatic rd(input logic [7:0] c, input logic w);
      HOST.xfer(1'b0, c, w, 16'h0000, r);
   endtask

   // restore pulse, settings visible at the next falling edge
   task automatic rl;
      @(negedge clk) reload = 1'b1;
      @(negedge clk) reload = 1'b0;
   endtask

   task automatic mt(input logic [6:0] a, input logic e);
      @(negedge clk) bus_addr = a;
      @(negedge clk);
      chk("addr_match", e, match);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      strap = '0;
      nvm   = '0;
      for (int k = 0; k < 9; k++) begin
         strap[k*16 +: 16] = 16'h5a00 | 16'(k);
         nvm[k*16 +: 16]   = 16'ha500 | 16'(k);
      end
      strap.addr = 16'h0011;
      nvm.addr   = 16'h0022;
      nvm_ovr    = 16'h0b2a;
      nvm_csum   = 16'h1234;
      reload     = 1'b0;
      bus_addr   = 7'h11;
      repeat (5) @(negedge clk);
      arst_n = 1'b1;
      repeat (4) @(negedge clk);
      bs = strap;
      chk("boot_ovr", nvm_ovr, ovr);
      chk("boot_cfg", pick(16'h0b2a, bs, nvm), cfg);
      strap = ~strap;
      wr(8'hee, 1'b1, 16'hffff);
      chk("ovr_now", 16'h1f3f, ovr);
      chk("cfg_held", pick(16'h0b2a, bs, nvm), cfg);
      rl();
      chk("cfg_strap", pick(16'h1f3f, bs, nvm), cfg);
      rd(8'hee, 1'b1);
      chk("ovr_read", {2'b10, 16'h1f3f}, r);
      wr(8'hee, 1'b1, 16'h0410);
      rl();
      chk("cfg_unused", nvm, cfg);
      mt(7'h22, 1'b1);
      // host already addresses the new target one cycle before the write is driven
      bus_addr = 7'h45;
      wr(8'hef, 1'b0, 16'h0045);
      chk("addr_ack", 2'b10, {r.ack, r.invalid});
      chk("addr_cfg", 16'h0045, cfg.addr);
      rd(8'hef, 1'b0);
      chk("addr_read", {2'b10, 8'h45}, {r.ack, r.invalid, r.data[7:0]});
      mt(7'h22, 1'b0);
      mt(7'h45, 1'b1);
      // reserved targets are refused and leave the address alone
      foreach (rsvd_list[i]) begin
         wr(8'hef, 1'b0, {9'h000, rsvd_list[i]});
         chk("rsvd_refused", 2'b01, {r.ack, r.invalid});
      end
      chk("addr_kept", 16'h0045, cfg.addr);
      wr(8'hef, 1'b1, 16'h0046);
      chk("addr_word_refused", 2'b01, {r.ack, r.invalid});
      rd(8'hed, 1'b1);
      chk("unknown_cmd", 2'b01, {r.ack, r.invalid});
      wr(8'hed, 1'b1, 16'h0000);
      chk("unknown_wr", 2'b01, {r.ack, r.invalid});
      wr(8'hee, 1'b0, 16'h0001);
      chk("ovr_byte_refused", 2'b01, {r.ack, r.invalid});
      chk("ovr_byte_kept", 16'h0410, ovr);
      rd(8'hef, 1'b1);
      chk("addr_word_read", 2'b01, {r.ack, r.invalid});
      rd(8'hf0, 1'b1);
      chk("csum_boot", {2'b10, 16'h1234}, r);
      nvm_csum = 16'h4321;
      rd(8'hf0, 1'b1);
      chk("csum_held", {2'b10, 16'h1234}, r);
      rl();
      rd(8'hf0, 1'b1);
      chk("csum_reload", {2'b10, 16'h4321}, r);
      wr(8'hf0, 1'b1, 16'h0000);
      chk("csum_write", 2'b01, {r.ack, r.invalid});
      rd(8'hf0, 1'b0);
      chk("csum_byte", 2'b01, {r.ack, r.invalid});
      end_of_test();
   end

   // watchdog well beyond the roughly 60 cycles the sequence needs
   initial begin
      #40000;
      n_mismatch++;
      end_of_test();
   end
endmodule
